// ===== src/pdtt_map.svh
// constants for the three-channel programmable down timer
// assumes a single 25 MHz clock; oscillators arrive as pins
// Operation
// - three 8-bit presettable down counters; 3x8 or 16+8 use
// - reload strobe copies reload value into its counter
// - run bit gates the count clock; stopped counter holds its value
// - low nibble read latches high nibble; software reads low first
// - underflow reloads counter and counting continues periodically
// - underflow feeds interrupt and pulse output; timer 2 feeds serial clock
// - source select: 0 slow oscillator, 1 fast oscillator
// - ratio field 00 /1, 01 /4, 10 /32, 11 /256
// - prescaler divides source clock only while run bit is one
// - event mode makes timer 0 count the event pin, ignoring prescaler
// - polarity 0 counts falling edges, 1 counts rising edges
// - noise reject accepts a change at second falling 2048 Hz tick
// - chain mode joins timer 0 low byte, timer 1 high byte
// - chained timer 1 steps on timer 0 underflow, own run, source and ratio ignored
// - underflow sets flag regardless of mask; mask gates request
// - chained: interrupt from timer 1, timer 0 flag not set
// - pulse output toggles on chosen timer underflow; select 1x/01/00
// - output enable gates pulse onto pin, low when off, asynchronously
`ifndef PDTT_MAP_SVH
`define PDTT_MAP_SVH

`define PDTT_TIMERS        3
`define PDTT_CNT_W         8
`define PDTT_NIB_W         4
`define PDTT_CNT_ZERO      8'h00
`define PDTT_CNT_DEC       8'h01
`define PDTT_CNT_RESET     8'h00

// prescaler terminal counts: ratio minus one
`define PDTT_RATIO_DIV1    2'b00
`define PDTT_RATIO_DIV4    2'b01
`define PDTT_RATIO_DIV32   2'b10
`define PDTT_RATIO_DIV256  2'b11
`define PDTT_TERM_DIV1     8'h00
`define PDTT_TERM_DIV4     8'h03
`define PDTT_TERM_DIV32    8'h1f
`define PDTT_TERM_DIV256   8'hff
`define PDTT_PRE_INC       8'h01

// 2048 Hz tick from 32768 Hz slow oscillator: one in sixteen
`define PDTT_NR_DIV_LAST   4'hf
`define PDTT_NR_DIV_INC    4'h1
`define PDTT_NR_DIV_RESET  4'h0

// pulse channel select codes
`define PDTT_CH_T0         2'b00
`define PDTT_CH_T1         2'b01
`define PDTT_CH_T2_BIT     1

`endif

// ===== src/pdtt_noise_filter.sv
// noise rejector for the event input
// assumes level_in is already synchronised and tick is the 2048 Hz fall
`timescale 1ns/100ps
`include "pdtt_map.svh"

module pdtt_noise_filter (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic level_in,
  input  wire logic tick,
  output logic      level_out
);

  pdtt_pkg::pdtt_nr_state_type state_q;
  logic                        level_q;

  // accept a change at the second tick after it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= pdtt_pkg::PDTT_NR_STABLE;
      level_q <= 1'b0;
    end else if (level_in == level_q) begin
      // short pulse: back to the old level, nothing counted
      state_q <= pdtt_pkg::PDTT_NR_STABLE;
    end else if (tick) begin
      unique case (state_q)
        pdtt_pkg::PDTT_NR_STABLE: begin
          state_q <= pdtt_pkg::PDTT_NR_ONE;
        end
        pdtt_pkg::PDTT_NR_ONE: begin
          state_q <= pdtt_pkg::PDTT_NR_STABLE;
          level_q <= level_in;
        end
      endcase
    end
  end

  assign level_out = level_q;

endmodule : pdtt_noise_filter

// ===== src/pdtt_pkg.sv
// types shared by the programmable down timer files
// assumes pdtt_map.svh supplies the numeric constants
package pdtt_pkg;

  // noise rejector progress after an input level change
  typedef enum logic [0:0] {
    PDTT_NR_STABLE = 1'b0,
    PDTT_NR_ONE    = 1'b1
  } pdtt_nr_state_type;

endpackage : pdtt_pkg

// ===== src/pdtt_prescaler.sv
// one prescaler: divides source ticks by 1, 4, 32 or 256
// assumes src_tick is a one-cycle pulse on clk
`timescale 1ns/100ps
`include "pdtt_map.svh"

module pdtt_prescaler (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic       src_tick,
  input  wire logic [1:0] ratio,
  output logic            step
);

  logic [7:0] div_q;
  logic [7:0] term;

  always_comb begin
    unique case (ratio)
      `PDTT_RATIO_DIV1:   term = `PDTT_TERM_DIV1;
      `PDTT_RATIO_DIV4:   term = `PDTT_TERM_DIV4;
      `PDTT_RATIO_DIV32:  term = `PDTT_TERM_DIV32;
      `PDTT_RATIO_DIV256: term = `PDTT_TERM_DIV256;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b || !run) begin
      div_q <= `PDTT_CNT_RESET;
    end else if (src_tick) begin
      if (div_q >= term) begin
        div_q <= `PDTT_CNT_RESET;
      end else begin
        div_q <= div_q + `PDTT_PRE_INC;
      end
    end
  end

  assign step = run && src_tick && (div_q >= term);

endmodule : pdtt_prescaler

// ===== src/pdtt_timer_trio.sv
// three 8-bit reloadable down timers with prescalers, event count,
// 16-bit chaining, interrupt flags, halved pulse and serial clock
// assumes oscillator and event pins are asynchronous to clk and
// that clk (25 MHz) is well above the fast oscillator rate
`timescale 1ns/100ps
`include "pdtt_map.svh"

module pdtt_timer_trio (
  input  wire logic        clk,
  input  wire logic        rst_b,
  // oscillator pins
  input  wire logic        slow_oscillator,
  input  wire logic        fast_oscillator,
  // external event source
  input  wire logic        event_input_pin,
  // per-timer control, bit i (or field i for ratio and reload) for timer i
  input  wire logic [2:0]  timer_reload_strobe,
  input  wire logic [2:0]  timer_run_bit,
  input  wire logic [2:0]  source_clock_select,
  input  wire logic [5:0]  prescale_ratio_field,
  input  wire logic [23:0] reload_value,
  // timer 0 mode control
  input  wire logic        event_count_mode,
  input  wire logic        event_edge_polarity,
  input  wire logic        noise_reject_enable,
  input  wire logic        chain_wide_mode,
  // interrupt control
  input  wire logic [2:0]  underflow_irq_mask,
  input  wire logic [2:0]  underflow_irq_clear,
  output logic      [2:0]  underflow_irq_flag,
  output logic             underflow_irq_req,
  // count readback, low nibble read latches the high nibble
  input  wire logic [2:0]  low_nibble_read,
  output logic      [11:0] count_readback_low,
  output logic      [11:0] count_readback_high,
  // pulse output
  input  wire logic [1:0]  pulse_channel_select,
  input  wire logic        pulse_output_enable,
  output logic             halved_pulse_out,
  output logic             pulse_port_pin,
  // serial interface clock source
  output logic             serial_clock_out
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************

  logic [1:0] slow_sync_q;
  logic [1:0] fast_sync_q;
  logic [1:0] evt_sync_q;
  logic       slow_prev_q;
  logic       fast_prev_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      slow_sync_q <= 2'h0;
      fast_sync_q <= 2'h0;
      evt_sync_q  <= 2'h0;
    end else begin
      slow_sync_q <= {slow_sync_q[0], slow_oscillator};
      fast_sync_q <= {fast_sync_q[0], fast_oscillator};
      evt_sync_q  <= {evt_sync_q[0], event_input_pin};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      slow_prev_q <= 1'b0;
      fast_prev_q <= 1'b0;
    end else begin
      slow_prev_q <= slow_sync_q[1];
      fast_prev_q <= fast_sync_q[1];
    end
  end

  // one-cycle ticks on rising oscillator edges
  logic slow_tick;
  logic fast_tick;

  assign slow_tick = slow_sync_q[1] && !slow_prev_q;
  assign fast_tick = fast_sync_q[1] && !fast_prev_q;

  // ****************************************************************
  // 2048 Hz tick for the noise rejector
  // ****************************************************************

  logic [3:0] nr_div_q;
  logic       nr_tick;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      nr_div_q <= `PDTT_NR_DIV_RESET;
    end else if (slow_tick) begin
      nr_div_q <= nr_div_q + `PDTT_NR_DIV_INC;
    end
  end

  // wrap of the divider stands for the falling edge of 2048 Hz
  assign nr_tick = slow_tick && (nr_div_q == `PDTT_NR_DIV_LAST);

  // ****************************************************************
  // event input path
  // ****************************************************************

  logic evt_filtered;
  logic evt_level;
  logic evt_prev_q;
  logic evt_step;

  pdtt_noise_filter u_filter (
    .clk       (clk),
    .rst_b     (rst_b),
    .level_in  (evt_sync_q[1]),
    .tick      (nr_tick),
    .level_out (evt_filtered)
  );

  // filtered level only when noise rejection is on
  assign evt_level = noise_reject_enable ? evt_filtered : evt_sync_q[1];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      evt_prev_q <= 1'b0;
    end else begin
      evt_prev_q <= evt_level;
    end
  end

  assign evt_step = event_edge_polarity ? (evt_level && !evt_prev_q)
                                        : (!evt_level && evt_prev_q);

  // ****************************************************************
  // prescalers
  // ****************************************************************

  logic [2:0] pre_run;
  logic [2:0] pre_step;

  // prescaler 0 idles in event mode; prescaler 1 in chain
  assign pre_run[0] = timer_run_bit[0] && !event_count_mode;
  assign pre_run[1] = timer_run_bit[1] && !chain_wide_mode;
  assign pre_run[2] = timer_run_bit[2];

  genvar gp;
  generate
    for (gp = 0; gp < `PDTT_TIMERS; gp = gp + 1) begin : g_pre
      logic src_tick;

      // slow or fast oscillator per timer
      assign src_tick = source_clock_select[gp] ? fast_tick : slow_tick;

      pdtt_prescaler u_pre (
        .clk      (clk),
        .rst_b    (rst_b),
        .run      (pre_run[gp]),
        .src_tick (src_tick),
        .ratio    (prescale_ratio_field[2*gp +: 2]),
        .step     (pre_step[gp])
      );
    end
  endgenerate

  // ****************************************************************
  // counter steps
  // ****************************************************************

  logic [2:0]  step;
  logic [2:0]  underflow;
  logic [23:0] cnt_q;

  always_comb begin
    // run bit gates the event clock too
    step[0] = event_count_mode ? (timer_run_bit[0] && evt_step)
                               : pre_step[0];
    // timer 1 steps on timer 0 underflow when chained
    step[1] = chain_wide_mode ? underflow[0] : pre_step[1];
    step[2] = pre_step[2];
  end

  // ****************************************************************
  // down counters, flags and readback latches
  // ****************************************************************

  logic [2:0]  flag_set;
  logic [2:0]  flag_q;
  logic [11:0] high_hold_q;

  // chained timer 0 underflow leaves its flag alone
  assign flag_set[0] = underflow[0] && !chain_wide_mode;
  assign flag_set[1] = underflow[1];
  assign flag_set[2] = underflow[2];

  genvar gt;
  generate
    for (gt = 0; gt < `PDTT_TIMERS; gt = gt + 1) begin : g_tmr
      logic [7:0] cnt;
      logic [7:0] reload;

      assign cnt    = cnt_q[8*gt +: 8];
      assign reload = reload_value[8*gt +: 8];

      // underflow is the step taken while at zero
      assign underflow[gt] = step[gt] && (cnt == `PDTT_CNT_ZERO);

      always_ff @(posedge clk) begin
        if (!rst_b) begin
          cnt_q[8*gt +: 8] <= `PDTT_CNT_RESET;
        end else if (timer_reload_strobe[gt]) begin
          cnt_q[8*gt +: 8] <= reload;
        end else if (underflow[gt]) begin
          cnt_q[8*gt +: 8] <= reload;
        end else if (step[gt]) begin
          cnt_q[8*gt +: 8] <= cnt - `PDTT_CNT_DEC;
        end
      end

      // set wins over a clear in the same cycle
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          flag_q[gt] <= 1'b0;
        end else if (flag_set[gt]) begin
          flag_q[gt] <= 1'b1;
        end else if (underflow_irq_clear[gt]) begin
          flag_q[gt] <= 1'b0;
        end
      end

      // low read freezes the high nibble against a borrow
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          high_hold_q[4*gt +: 4] <= 4'h0;
        end else if (low_nibble_read[gt]) begin
          high_hold_q[4*gt +: 4] <= cnt[7:4];
        end
      end

      assign count_readback_low[4*gt +: 4]  = cnt[3:0];
      assign count_readback_high[4*gt +: 4] = high_hold_q[4*gt +: 4];
    end
  endgenerate

  // ****************************************************************
  // interrupt request
  // ****************************************************************

  // mask gates only the request, never the flag
  assign underflow_irq_flag = flag_q;
  assign underflow_irq_req  = |(flag_q & underflow_irq_mask);

  // ****************************************************************
  // halved pulse and serial clock
  // ****************************************************************

  logic pulse_src;
  logic halved_q;
  logic serial_q;

  // channel select: 1x timer 2, 01 timer 1, 00 timer 0
  always_comb begin
    if (pulse_channel_select[`PDTT_CH_T2_BIT]) begin
      pulse_src = underflow[2];
    end else if (pulse_channel_select == `PDTT_CH_T1) begin
      pulse_src = underflow[1];
    end else begin
      pulse_src = underflow[0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      halved_q <= 1'b0;
    end else if (pulse_src) begin
      halved_q <= !halved_q;
    end
  end

  // timer 2 underflow drives the serial clock, halved
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      serial_q <= 1'b0;
    end else if (underflow[2]) begin
      serial_q <= !serial_q;
    end
  end

  assign halved_pulse_out = halved_q;
  assign serial_clock_out = serial_q;

  // plain gate: a sliver may escape when the enable flips
  assign pulse_port_pin = halved_q && pulse_output_enable;

endmodule : pdtt_timer_trio

// ===== verif/pdtt_event_source.sv
// model of the external event source on the event input pin
// assumes the bench asks for a burst by a one-cycle start pulse
`timescale 1ns/100ps

module pdtt_event_source (
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic [15:0] half_len,
  output logic             event_pin,
  output logic             busy
);
  initial begin
    event_pin = 1'b0;
    busy = 1'b0;
  end

  // ****************************
  // three pulses per burst
  // ****************************
  // level hold times
  // bench picks half_len; short values exercise the rejector on purpose
  always begin
    @(posedge clk iff start);
    busy = 1'b1;
    repeat (3) begin
      #1 event_pin = 1'b1;
      repeat (half_len) @(posedge clk);
      #1 event_pin = 1'b0;
      repeat (half_len) @(posedge clk);
    end
    busy = 1'b0;
  end
endmodule : pdtt_event_source

// ===== verif/pdtt_timer_trio_asserts.sv
// port-level checker for the down timer trio
// assumes the bench holds reload values steady while timers run
`timescale 1ns/100ps

module pdtt_timer_trio_asserts (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [2:0]  timer_reload_strobe,
  input wire logic [2:0]  timer_run_bit,
  input wire logic [23:0] reload_value,
  input wire logic        chain_wide_mode,
  input wire logic [2:0]  underflow_irq_mask,
  input wire logic [2:0]  underflow_irq_clear,
  input wire logic [2:0]  underflow_irq_flag,
  input wire logic        underflow_irq_req,
  input wire logic [2:0]  low_nibble_read,
  input wire logic [11:0] count_readback_low,
  input wire logic [11:0] count_readback_high,
  input wire logic        pulse_output_enable,
  input wire logic        halved_pulse_out,
  input wire logic        pulse_port_pin,
  input wire logic        serial_clock_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_reload_copy:
  assert property (timer_reload_strobe[0] |=> count_readback_low[3:0]
    == $past(reload_value[3:0])) else $error("reload not copied");
  a_pin_gating:
  assert property (pulse_port_pin == (halved_pulse_out & pulse_output_enable))
    else $error("pin gating wrong");
  a_req_masked:
  assert property (underflow_irq_req == |(underflow_irq_flag
    & underflow_irq_mask)) else $error("request not flag and mask");
  a_flag_sticky:
  assert property (underflow_irq_flag[0] && !underflow_irq_clear[0]
    |=> underflow_irq_flag[0]) else $error("flag lost");
  a_chain_no_flag:
  assert property (chain_wide_mode && $past(chain_wide_mode)
    |-> !$rose(underflow_irq_flag[0])) else $error("t0 flag in chain");
  a_serial_reload:
  assert property ($changed(serial_clock_out) |-> count_readback_low[11:8]
    == reload_value[19:16]) else $error("serial toggle off underflow");
  a_flag_reload:
  assert property ($rose(underflow_irq_flag[2]) |-> count_readback_low[11:8]
    == reload_value[19:16]) else $error("no reload at underflow");
  a_high_hold:
  assert property (!low_nibble_read[0] |=> $stable(count_readback_high[3:0]))
    else $error("held nibble moved");
  a_stop_hold:
  assert property (!timer_run_bit[2] && $past(!timer_run_bit[2], 2)
    && $past(!timer_run_bit[2]) && !timer_reload_strobe[2]
    |=> $stable(count_readback_low[11:8])) else $error("stopped count moved");
endmodule : pdtt_timer_trio_asserts

bind pdtt_timer_trio pdtt_timer_trio_asserts pdtt_timer_trio_asserts_inst (
  .clk, .rst_b, .timer_reload_strobe, .timer_run_bit, .reload_value,
  .chain_wide_mode, .underflow_irq_mask, .underflow_irq_clear,
  .underflow_irq_flag, .underflow_irq_req, .low_nibble_read,
  .count_readback_low, .count_readback_high, .pulse_output_enable,
  .halved_pulse_out, .pulse_port_pin, .serial_clock_out);

// ===== verif/testbench.sv
// self-checking bench for the down timer trio
// assumes scaled oscillators: slow tick every 8 clk, fast every 6 clk
`timescale 1ns/100ps

module testbench;
  typedef struct {
    int         idx;
    logic [1:0] ratio;
    logic       sel;
    logic [7:0] rld;
    int         period;
  } pdtt_row_type;

  logic        clk, rst_b, slow_osc, fast_osc, ev_pin, ev_start, ev_busy;
  logic [2:0]  strobe, run, sel, mask, clr, flag, rd, slow_cnt, fast_cnt;
  logic [5:0]  ratio;
  logic [23:0] rld;
  logic [11:0] lo, hi;
  logic [1:0]  chsel;
  logic        evm, pol, nr, chain, oe, req, halved, pin, sclk;
  logic [15:0] half_len;
  logic [7:0]  v1, v2;
  int          fail_count, checks, n, i;
  // period in clk: (reload + 1) * ratio * source period
  pdtt_row_type rows [6] = '{'{0, 2'h0, 1'b0, 8'h05, 48},
    '{1, 2'h1, 1'b1, 8'h02, 72}, '{2, 2'h2, 1'b0, 8'h01, 512},
    '{2, 2'h3, 1'b0, 8'h00, 2048}, '{0, 2'h1, 1'b0, 8'hff, 8192},
    '{1, 2'h0, 1'b1, 8'h00, 6}};

  pdtt_timer_trio pdtt_timer_trio_inst (.clk(clk), .rst_b(rst_b),
    .slow_oscillator(slow_osc), .fast_oscillator(fast_osc),
    .event_input_pin(ev_pin), .timer_reload_strobe(strobe),
    .timer_run_bit(run), .source_clock_select(sel),
    .prescale_ratio_field(ratio), .reload_value(rld),
    .event_count_mode(evm), .event_edge_polarity(pol),
    .noise_reject_enable(nr), .chain_wide_mode(chain),
    .underflow_irq_mask(mask), .underflow_irq_clear(clr),
    .underflow_irq_flag(flag), .underflow_irq_req(req),
    .low_nibble_read(rd), .count_readback_low(lo),
    .count_readback_high(hi), .pulse_channel_select(chsel),
    .pulse_output_enable(oe), .halved_pulse_out(halved),
    .pulse_port_pin(pin), .serial_clock_out(sclk));

  pdtt_event_source pdtt_event_source_inst (.clk(clk), .start(ev_start),
    .half_len(half_len), .event_pin(ev_pin), .busy(ev_busy));

  always #20 clk = ~clk;

  // fast source stable
  // fast oscillator runs from time zero, long before any timer starts
  always @(posedge clk) begin
    slow_cnt <= slow_cnt + 3'h1;
    fast_cnt <= (fast_cnt == 3'h5) ? 3'h0 : fast_cnt + 3'h1;
  end
  assign slow_osc = slow_cnt[2];
  assign fast_osc = fast_cnt < 3'h3;

  task automatic tick(input int k = 1);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic read_cnt(input int t, output logic [7:0] v);
    rd[t] = 1'b1;
    tick();
    rd[t] = 1'b0;
    v = {hi[4*t+:4], lo[4*t+:4]};
  endtask : read_cnt

  task automatic wait_flag(input int t);
    int k;
    for (k = 0; k < 20000 && flag[t] !== 1'b1; k++) tick();
    chk(k < 20000, 1);
    clr[t] = 1'b1;
    tick();
    clr[t] = 1'b0;
  endtask : wait_flag

  task automatic period(input int t, output int p);
    time t0;
    wait_flag(t);
    t0 = $time;
    wait_flag(t);
    p = int'(($time - t0) / 40);
  endtask : period

  task automatic burst;
    ev_start = 1'b1;
    tick();
    ev_start = 1'b0;
  endtask : burst

  initial begin
    {clk, rst_b, strobe, run, sel, mask, clr, rd, ratio, rld} = '0;
    {chsel, evm, pol, nr, chain, oe, ev_start, slow_cnt, fast_cnt} = '0;
    half_len = 16'h0028;
    tick(2);
    rst_b = 1'b1;
    chk({flag, req, halved, pin, sclk, lo, hi}, 0);
    mask = 3'h7;
    oe = 1'b1;
    foreach (rows[r]) begin
      i = rows[r].idx;
      ratio[2*i+:2] = rows[r].ratio;
      sel[i] = rows[r].sel;
      rld[8*i+:8] = rows[r].rld;
      chsel = 2'(i);
      strobe[i] = 1'b1;
      tick();
      strobe = 3'h0;
      read_cnt(i, v1);
      chk(v1, rows[r].rld);
      run[i] = 1'b1;
      period(i, n);
      chk(n, rows[r].period);
      run = 3'h0;
      tick(3);
      clr = 3'h7;
      tick();
      clr = 3'h0;
    end
    // ****************************
    // stop and resume
    // ****************************
    rld[23:16] = 8'h80;
    ratio[5:4] = 2'h0;
    strobe[2] = 1'b1;
    tick();
    strobe = 3'h0;
    run[2] = 1'b1;
    tick(100);
    run[2] = 1'b0;
    tick(4);
    read_cnt(2, v1);
    tick(200);
    read_cnt(2, v2);
    chk(v2, v1);
    chk(v1 < 8'h80, 1);
    run[2] = 1'b1;
    tick(100);
    run[2] = 1'b0;
    tick(4);
    read_cnt(2, v2);
    chk(v2 < v1, 1);
    // ****************************
    // event counting
    // ****************************
    rld[7:0] = 8'h10;
    evm = 1'b1;
    run[0] = 1'b1;
    for (int p = 0; p < 4; p++) begin
      pol = p[0] | p[1];
      nr = p[1];
      half_len = (p == 3) ? 16'h0008 : (p == 2) ? 16'h012c : 16'h0028;
      strobe[0] = 1'b1;
      tick();
      strobe = 3'h0;
      burst();
      tick(20);
      if (p < 2) chk(lo[3:0], p ? 4'hf : 4'h0);
      for (int k = 0; k < 5000 && ev_busy; k++) tick();
      tick(300);
      chk(lo[3:0], (p == 3) ? 4'h0 : 4'hd);
    end
    {evm, nr, run} = '0;
    // ****************************
    // chained pair and masking
    // ****************************
    chain = 1'b1;
    rld[15:0] = 16'h0101;
    ratio[1:0] = 2'h0;
    sel[0] = 1'b0;
    mask = 3'h2;
    strobe = 3'h3;
    tick();
    strobe = 3'h0;
    clr = 3'h7;
    tick();
    clr = 3'h0;
    run[0] = 1'b1;
    period(1, n);
    chk(n, 32);
    chk(flag[0], 0);
    mask = 3'h0;
    for (int k = 0; k < 200 && flag[1] !== 1'b1; k++) tick();
    chk({flag[1], req}, 2'b10);
    mask = 3'h2;
    tick();
    chk(req, 1);
    // halved pulse follows chained timer 1
    chsel = 2'h1;
    wait_flag(1);
    v1[0] = halved;
    wait_flag(1);
    chk(halved, !v1[0]);
    chk(pin, halved);
    oe = 1'b0;
    tick();
    chk(pin, 0);
    // serial clock toggles on timer 2 underflow
    rld[23:16] = 8'h00;
    ratio[5:4] = 2'h0;
    strobe[2] = 1'b1;
    tick();
    strobe = 3'h0;
    run[2] = 1'b1;
    v1[1] = sclk;
    wait_flag(2);
    chk(sclk, !v1[1]);
    stop_test();
  end

  initial begin
    tick(90000);
    fail_count++;
    stop_test();
  end
endmodule : testbench
